// *** nand_tree_board_test.v ***
// Pin-side wrapper for the board connectivity test mode.
// Assumes PCI pins are sampled synchronously to clock and the PCI
// functional core supplies the normal output values and enables.
`timescale 1ns/1ns
`include "nand_tree_board_test_regs.vh"
module nand_tree_board_test
#(
   parameter CHAIN_WIDTH = `CHAIN_WIDTH
)
(
   // Clock and reset
   input wire clock,
   input wire resetn,
   // PCI pin inputs (levels seen on the pins)
   input wire pci_rst_n,
   input wire inta_n_in,
   input wire pci_clk_in,
   input wire gnt_n_in,
   input wire req_n_in,
   input wire [31:0] ad_in,
   input wire [3:0] cbe_n_in,
   input wire idsel_in,
   input wire frame_n_in,
   input wire irdy_n_in,
   input wire trdy_n_in,
   input wire devsel_n_in,
   input wire stop_n_in,
   input wire lock_n_in,
   input wire perr_n_in,
   input wire serr_n_in,
   input wire par_in,
   input wire power_down_request_in,
   // SCSI bus conditions, active low
   input wire scsi_bsy_n,
   input wire scsi_sel_n,
   // Normal drive values and enables from the PCI core
   input wire [31:0] core_ad_out,
   input wire core_ad_oe,
   input wire [3:0] core_cbe_n_out,
   input wire core_cbe_oe,
   input wire core_par_out,
   input wire core_par_oe,
   input wire [4:0] core_ctl_n_out,
   input wire [4:0] core_ctl_oe,
   input wire core_perr_n_out,
   input wire core_perr_oe,
   input wire core_serr_oe,
   input wire core_inta_oe,
   input wire core_req_n_out,
   input wire core_req_oe,
   // PCI pin drive values and enables
   output reg [31:0] ad_out,
   output reg ad_oe,
   output reg [3:0] cbe_n_out,
   output reg cbe_oe,
   output reg par_out,
   output reg par_oe,
   output reg [4:0] ctl_n_out,
   output reg [4:0] ctl_oe,
   output reg perr_n_out,
   output reg perr_oe,
   output reg serr_n_out,
   output reg serr_oe,
   output reg inta_n_out,
   output reg inta_oe,
   output reg req_n_out,
   output reg req_oe,
   // Activity output and status toward the core
   output reg busy_n_out,
   output reg test_mode_out,
   output reg power_down_core
);

   wire [CHAIN_WIDTH-1:0] chain_pins;
   wire [4:0] head_pins;
   wire [17:0] upper_pins;
   wire [9:0] control_pins;
   wire [17:0] lower_pins;
   wire chain_result;
   wire run_normal;
   reg busy_n_nxt;

   // Enable gate shared by every pin enable except the five control strobes, which are masked inline; test mode always wins
   function gate_oe;
      input oe;
      input normal;
      begin
         gate_oe = oe & normal;
      end
   endfunction

   // Test mode follows the PCI reset pin directly
   assign run_normal = pci_rst_n;

   // Head of the chain: reset first, then interrupt, then clock
   assign head_pins = {
      pci_rst_n,
      inta_n_in,
      pci_clk_in,
      gnt_n_in,
      req_n_in
   };

   // Upper address bytes around byte enable three and select
   assign upper_pins = {ad_in[31:24], cbe_n_in[3], idsel_in,
      ad_in[23:16]};

   // Byte enable two and the control strobes; lock is input only
   assign control_pins = {
      cbe_n_in[2],
      frame_n_in,
      irdy_n_in,
      trdy_n_in,
      devsel_n_in,
      stop_n_in,
      lock_n_in,
      perr_n_in,
      serr_n_in,
      par_in
   };

   // Lower address bytes with byte enables one and zero
   assign lower_pins = {cbe_n_in[1], ad_in[15:8], cbe_n_in[0],
      ad_in[7:0]};

   // Full order, first stage in the top bit; no-connect and supply absent
   assign chain_pins = {head_pins, upper_pins, control_pins, lower_pins,
      power_down_request_in};

   nand_chain
   #(
      .WIDTH(CHAIN_WIDTH)
   )
   u_chain
   (
      .chain_in(chain_pins),
      .chain_out(chain_result)
   );

   // Activity source: chain in test mode, else busy OR select
   always @*
   begin
      busy_n_nxt = scsi_bsy_n & scsi_sel_n;
      if (!run_normal)
         busy_n_nxt = chain_result;
   end

   // Registered activity pin; one cycle behind the pins it reports
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         busy_n_out <= `BUSY_N_RESET;
      else
         busy_n_out <= busy_n_nxt;
   end

   // Mode flag for the core, high while PCI reset was low
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         test_mode_out <= 1'b0;
      else
         test_mode_out <= ~run_normal;
   end

   // Power-down request reaches the core only outside test mode
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         power_down_core <= `PD_REQ_RESET;
      else
         power_down_core <= power_down_request_in & run_normal;
   end

   // Pin drive values follow the core, open-drain ones fixed low; harmless while enables are off
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         ad_out <= `AD_OUT_RESET;
         cbe_n_out <= `CBE_N_RESET;
         par_out <= `PAR_OUT_RESET;
         ctl_n_out <= `CTL_N_RESET;
         perr_n_out <= `PERR_N_RESET;
         serr_n_out <= `OPEN_DRAIN_LOW;
         inta_n_out <= `OPEN_DRAIN_LOW;
         req_n_out <= `REQ_N_RESET;
      end
      else
      begin
         ad_out <= core_ad_out;
         cbe_n_out <= core_cbe_n_out;
         par_out <= core_par_out;
         ctl_n_out <= core_ctl_n_out;
         perr_n_out <= core_perr_n_out;
         // Open-drain pins only ever pull low
         serr_n_out <= `OPEN_DRAIN_LOW;
         inta_n_out <= `OPEN_DRAIN_LOW;
         req_n_out <= core_req_n_out;
      end
   end

   // Pin drive enables, all forced off while PCI reset is low
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         ad_oe <= `OE_RESET;
         cbe_oe <= `OE_RESET;
         par_oe <= `OE_RESET;
         ctl_oe <= `CTL_OE_RESET;
         perr_oe <= `OE_RESET;
         serr_oe <= `OE_RESET;
         inta_oe <= `OE_RESET;
         req_oe <= `OE_RESET;
      end
      else
      begin
         ad_oe <= gate_oe(core_ad_oe, run_normal);
         cbe_oe <= gate_oe(core_cbe_oe, run_normal);
         par_oe <= gate_oe(core_par_oe, run_normal);
         ctl_oe <= core_ctl_oe & {5{run_normal}};
         perr_oe <= gate_oe(core_perr_oe, run_normal);
         serr_oe <= gate_oe(core_serr_oe, run_normal);
         inta_oe <= gate_oe(core_inta_oe, run_normal);
         req_oe <= gate_oe(core_req_oe, run_normal);
      end
   end

endmodule

// *** nand_tree_board_test_regs.vh ***
// Constants for the board connectivity test block.
// Assumes one clock domain. No software registers exist in this block.
//
// Overview of operation
// - PCI reset low turns every PCI pin into an input and enables chain.
// - Chain result is shown on the bus activity output during test mode.
// - Chain has 52 inputs: reset, interrupt, clock, other PCI pins, power-down.
// - No-connect and supply pins are not in the chain.
// - Only reset low, all others high: activity output is low.
// - Each further input pulled low in chain order toggles activity output.
// - All chain inputs low: activity output is high.
// - Releasing PCI reset leaves test mode and restores normal pin use.
// - Outside test mode activity output is SCSI busy OR select.
// - During PCI reset the power-down input only feeds the chain.
`ifndef NAND_TREE_BOARD_TEST_REGS_VH
`define NAND_TREE_BOARD_TEST_REGS_VH

// Number of chained pins
`define CHAIN_WIDTH 52
// Activity output idle level (active low, so inactive is high)
`define BUSY_N_RESET 1'b1
// Pin drivers are released while in reset
`define OE_RESET 1'b0
`define CTL_OE_RESET 5'h00
// Power-down request to the core is inactive at reset
`define PD_REQ_RESET 1'b0
// Pin drive values held while the block is in reset
`define AD_OUT_RESET 32'h0000_0000
`define CBE_N_RESET 4'hf
`define PAR_OUT_RESET 1'b0
`define CTL_N_RESET 5'h1f
`define PERR_N_RESET 1'b1
`define REQ_N_RESET 1'b1
// Open-drain pins only ever pull low
`define OPEN_DRAIN_LOW 1'b0

`endif

// *** nand_chain.v ***
// Cascaded NAND chain for pin connectivity checking.
// Assumes inputs are static levels; purely combinational.
`timescale 1ns/1ns
module nand_chain
#(
   parameter WIDTH = 52
)
(
   // Chain inputs, bit WIDTH-1 is the first stage
   input wire [WIDTH-1:0] chain_in,
   // Result of the last stage
   output wire chain_out
);

   wire [WIDTH:0] stage;

   // Seed of the first stage is a constant one
   assign stage[WIDTH] = 1'b1;

   // Each stage combines the previous result with its own pin
   genvar k;
   generate
      for (k = 0; k < WIDTH; k = k + 1)
      begin : g_stage
         assign stage[k] = ~(stage[k+1] & chain_in[k]);
      end
   endgenerate

   assign chain_out = stage[0];

endmodule

// *** nand_tree_board_test_chk.sv ***
// Checker on the test block ports.
// Assumes one clock and an active-low reset.
`timescale 1ns/1ns
module nand_tree_board_test_chk
(
   // Watched ports
   input wire logic clock, resetn, pci_rst_n, scsi_bsy_n, scsi_sel_n,
   input wire logic core_ad_oe, power_down_request_in, ad_oe,
   input wire logic busy_n_out, test_mode_out, power_down_core
);
   // One domain, one disable
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   chk_ad_off: assert property (!pci_rst_n |=> !ad_oe)
      else $error("ad on");
   chk_mode_flag: assert property (1 |=> test_mode_out != $past(pci_rst_n))
      else $error("mode");
   chk_busy_scsi: assert property (pci_rst_n |=>
      busy_n_out == $past(scsi_bsy_n & scsi_sel_n)) else $error("busy");
   chk_pd_off: assert property (!pci_rst_n |=> !power_down_core)
      else $error("pd on");
   chk_pd_pass: assert property (pci_rst_n |=>
      power_down_core == $past(power_down_request_in)) else $error("pd");
   chk_oe_back: assert property ($rose(pci_rst_n) |=>
      ad_oe == $past(core_ad_oe)) else $error("oe");
   chk_mode_exit: assert property (!pci_rst_n ##1 pci_rst_n |=>
      !test_mode_out) else $error("exit");
   chk_mode_hold: assert property (!pci_rst_n [*3] |=>
      test_mode_out && !ad_oe) else $error("hold");
   // Entry, chain toggle and exit
   cover property ($fell(pci_rst_n));
   cover property (test_mode_out && $changed(busy_n_out));
   cover property ($rose(pci_rst_n));
endmodule
bind nand_tree_board_test nand_tree_board_test_chk chk (.*);

// *** board_tester.sv ***
// Tester model driving the 52 chained pins.
// Assumes bit 51 is the reset pin; pins move on the falling edge.
`timescale 1ns/1ns
module board_tester
(
   // Clock, request and test mode seen
   input wire clock,
   input wire go,
   input wire mode,
   // Test pattern and idle traffic
   input wire [51:0] pat,
   input wire [51:0] noise,
   // Pin levels
   output reg [51:0] chain
);
   // Live traffic when idle; pins held until test mode is seen
   initial chain = {1'b1, 51'h0};
   always @(negedge clock)
      if (!go)
         chain <= {1'b1, noise[50:0]};
      else if (mode)
         chain <= {1'b0, pat[50:0]};
      else
         chain[51] <= 1'b0;
endmodule

// *** nand_tree_board_test_tb.sv ***
// Bench for the connectivity test block.
// Assumes the tester model and checker are compiled first.
`timescale 1ns/1ns
module nand_tree_board_test_tb;
   reg clock = 0, resetn = 0, go = 0;
   reg [57:0] k = 0;
   reg [51:0] p = {52{1'b1}}, n = 0;
   integer seed = 32'hd7fa, failures = 0, comparisons = 0, m;
   wire [51:0] c;
   wire ad_oe, busy, tm, pd;
   wire [45:0] pin_val;
   wire [10:0] pin_oe;
   // Enables expected: core request, forced off while PCI reset is low
   wire [10:0] oe_exp = {k[37], k[39], k[49:45], k[51], k[52], k[53],
      k[55]} & {11{c[51]}};
   // Values expected: core values, open-drain pins always pull low
   wire [45:0] val_exp = {k[31:0], k[36:33], k[38], k[44:40], k[50],
      2'b00, k[54]};
   always #5 clock = ~clock;
   board_tester tester (.clock(clock), .go(go), .mode(tm), .pat(p),
      .noise(n), .chain(c));
   nand_tree_board_test DUT (.clock(clock), .resetn(resetn),
      .pci_rst_n(c[51]), .inta_n_in(c[50]), .pci_clk_in(c[49]),
      .gnt_n_in(c[48]), .req_n_in(c[47]), .ad_in({c[46:39], c[36:29],
      c[17:10], c[8:1]}), .cbe_n_in({c[38], c[28], c[18], c[9]}),
      .idsel_in(c[37]), .frame_n_in(c[27]), .irdy_n_in(c[26]),
      .trdy_n_in(c[25]), .devsel_n_in(c[24]), .stop_n_in(c[23]),
      .lock_n_in(c[22]), .perr_n_in(c[21]), .serr_n_in(c[20]), .par_in(c[19]),
      .power_down_request_in(c[0]), .scsi_bsy_n(k[56]), .scsi_sel_n(k[57]),
      .core_ad_out(k[31:0]), .core_ad_oe(k[32]), .core_cbe_n_out(k[36:33]),
      .core_cbe_oe(k[37]), .core_par_out(k[38]), .core_par_oe(k[39]),
      .core_ctl_n_out(k[44:40]), .core_ctl_oe(k[49:45]),
      .core_perr_n_out(k[50]), .core_perr_oe(k[51]), .core_serr_oe(k[52]),
      .core_inta_oe(k[53]), .core_req_n_out(k[54]), .core_req_oe(k[55]),
      .ad_out(pin_val[45:14]), .ad_oe(ad_oe), .cbe_n_out(pin_val[13:10]),
      .cbe_oe(pin_oe[10]), .par_out(pin_val[9]), .par_oe(pin_oe[9]),
      .ctl_n_out(pin_val[8:4]), .ctl_oe(pin_oe[8:4]),
      .perr_n_out(pin_val[3]), .perr_oe(pin_oe[3]), .serr_n_out(pin_val[2]),
      .serr_oe(pin_oe[2]), .inta_n_out(pin_val[1]), .inta_oe(pin_oe[1]),
      .req_n_out(pin_val[0]), .req_oe(pin_oe[0]), .busy_n_out(busy),
      .test_mode_out(tm), .power_down_core(pd));
   // Chain result, first input at bit 51
   function f(input [51:0] v);
      integer i;
      begin
         f = 1;
         for (i = 51; i >= 0; i = i - 1)
            f = !(f & v[i]);
      end
   endfunction
   // Count of low pins leading from the first chain input
   function integer lead(input [51:0] v);
      integer i;
      begin
         lead = 0;
         for (i = 51; i >= 0; i = i - 1)
            if (!v[i] && lead == 51 - i)
               lead = lead + 1;
      end
   endfunction
   task cmpw(input [63:0] g, input [63:0] e);
      begin
         comparisons = comparisons + 1;
         if (g !== e)
         begin
            failures = failures + 1;
            $display("MISMATCH %0t word %h", $time, g);
         end
      end
   endtask
   task cmp(input g, input e);
      begin
         comparisons = comparisons + 1;
         if (g !== e)
         begin
            failures = failures + 1;
            $display("MISMATCH %0t got %b", $time, g);
         end
      end
   endtask
   // Inputs still hold what the last rising edge took
   task cyc;
      begin
         @(negedge clock);
         cmp(busy, c[51] ? k[56] & k[57] : f(c));
         cmp(ad_oe, c[51] & k[32]);
         cmp(pd, c[51] & c[0]);
         cmp(tm, !c[51]);
         cmpw(pin_oe, oe_exp);
         cmpw(pin_val, val_exp);
         // Walk shape: leading lows then highs, busy high on even count
         if (!c[51] && c == ({52{1'b1}} >> lead(c)))
            cmp(busy, lead(c) % 2 == 0);
         k <= 58'({$random(seed), $random(seed)});
         n <= 52'({$random(seed), $random(seed)});
      end
   endtask
   task results;
      begin
         $display("comparisons %0d failures %0d", comparisons, failures);
         if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // Main sequence: normal, walk, random chain, exit
   initial
   begin
      repeat (12) @(negedge clock);
      resetn = 1;
      repeat (20) cyc;
      $display("normal done");
      go <= 1;
      for (m = 0; m < 60; m = m + 1)
      begin
         if (m > 7)
            p <= {1'b1, {51{1'b1}} >> (m - 8)};
         cyc;
      end
      $display("walk done");
      repeat (20)
      begin
         p <= 52'({$random(seed), $random(seed)});
         cyc;
      end
      $display("random done");
      go <= 0;
      repeat (5) cyc;
      $display("exit done");
      results;
   end
   // Hang guard, about seventeen times the run
   initial
   begin
      #20000;
      failures = failures + 1;
      results;
   end
endmodule
